// *** logic/scsw_pkg.sv ***
// scsw_pkg: constants and carrier types for the system clock source switch
// assumes an apb slave at 10 MHz and oscillator sources sampled as pins
package scsw_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] CLK_SEL_CTRL_OFF = 8'h00;
    localparam logic [7:0] TIMER1_CTRL_OFF = 8'h04;
    localparam logic [7:0] OSC_TRIM_OFF = 8'h08;
    localparam logic [7:0] CFG_STATUS_OFF = 8'h0c;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int IDLE_BIT = 7;
    localparam int FREQ_LSB = 4;
    localparam int PSD_BIT = 3;
    localparam int IFS_BIT = 2;
    localparam int SEC_ACT_BIT = 6;
    localparam int SEC_EN_BIT = 3;
    localparam int LFS_BIT = 7;
    localparam int PLL_BIT = 6;

    // ----------------------------------------------------------------
    // reset values and encodings
    // ----------------------------------------------------------------
    localparam logic [2:0] FREQ_RESET = 3'h4;
    localparam logic [2:0] FREQ_8M = 3'h7;
    localparam logic [2:0] FREQ_4M = 3'h6;
    localparam logic [2:0] FREQ_31K = 3'h0;
    localparam logic [1:0] SRC_PRIMARY = 2'h0;
    localparam logic [1:0] SRC_SECONDARY = 2'h1;
    localparam logic [3:0] CFG_INTERNAL_A = 4'h8;
    localparam logic [3:0] CFG_INTERNAL_B = 4'h9;
    localparam logic [3:0] CFG_XTAL_MAX = 4'h2;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int STARTUP_CYCLES = 1024;
    localparam int OLD_EDGES = 2;
    localparam int NEW_EDGES = 3;
    localparam int STABLE_CYCLES = 8;

    typedef enum logic [1:0] {
        SCSW_RUN = 2'b00,
        SCSW_DRAIN = 2'b01,
        SCSW_FILL = 2'b10
    } scsw_sw_t;

    typedef struct packed {
        logic [31:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } scsw_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } scsw_apb_rsp_t;

    typedef struct packed {
        logic idle_on_sleep;
        logic [2:0] internal_freq_select;
        logic [1:0] clock_source_select;
        logic secondary_osc_enable;
        logic low_freq_source_select;
        logic freq_multiplier_enable;
        scsw_sw_t sw;
        logic [1:0] cur_src;
        logic [1:0] cur_int_freq;
        logic [2:0] edge_cnt;
        logic [10:0] ost_cnt;
        logic primary_ready;
        logic [3:0] ifs_cnt;
        logic [7:0] div_cnt;
        logic div_clk;
        logic clk_out;
        logic [2:0] prim_sync;
        logic [2:0] sec_sync;
        logic [2:0] fast_sync;
        logic [2:0] slow_sync;
        logic [2:0] tss_sync;
        logic boot_seen;
        logic [31:0] prdata;
    } scsw_state_t;

endpackage

// *** logic/scsw_clock_switch.sv ***
// scsw_clock_switch: device clock source selection with apb registers
// assumes oscillator inputs are asynchronous and slower than pclk / 2
`timescale 1ns/1ps

module scsw_clock_switch (
    input wire logic pclk,
    input wire logic presetn,
    input wire scsw_pkg::scsw_apb_req_t apb_req,
    output scsw_pkg::scsw_apb_rsp_t apb_rsp,
    input wire logic primary_osc,
    input wire logic secondary_osc,
    input wire logic fast_internal_osc,
    input wire logic slow_internal_rc,
    input wire logic [3:0] primary_osc_config,
    input wire logic two_speed_startup_cfg,
    input wire logic sleep_request,
    output logic device_clk,
    output logic watchdog_clk,
    output logic fast_osc_enable,
    output logic secondary_osc_run,
    output logic idle_mode,
    output logic sleep_mode
);
    import scsw_pkg::*;

    scsw_state_t s_ff;
    scsw_state_t nxt_s;

    // ----------------------------------------------------------------
    // decoded helpers
    // ----------------------------------------------------------------
    logic wr_en;
    logic rd_en;
    logic hit;
    logic [7:0] ctrl_rd;
    logic [1:0] req_src;
    logic [1:0] want_src;
    logic new_edge;
    logic old_edge;
    logic src_lvl;
    logic [1:0] want_f;
    logic pll_allowed;
    logic sec_active;
    logic fast_rise;
    logic xtal_mode;
    logic int_sel;

    assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd_en = apb_req.psel & ~apb_req.pwrite & ~apb_req.penable;
    assign hit = apb_req.paddr[7:0] == CLK_SEL_CTRL_OFF ||
        apb_req.paddr[7:0] == TIMER1_CTRL_OFF ||
        apb_req.paddr[7:0] == OSC_TRIM_OFF ||
        apb_req.paddr[7:0] == CFG_STATUS_OFF;
    assign xtal_mode = primary_osc_config <= CFG_XTAL_MAX;
    assign sec_active = secondary_osc_run & (s_ff.cur_src == SRC_SECONDARY) &
        (s_ff.sw == SCSW_RUN);
    assign int_sel = s_ff.cur_src[1];

    function automatic logic src_level(input scsw_state_t st,
                                       input logic [1:0] src);
        logic v;
        v = 1'b0;
        if (src[1]) begin
            v = st.cur_int_freq == 2'h0 ? st.slow_sync[2] : st.div_clk;
        end else if (src[0]) begin
            v = st.sec_sync[2];
        end else begin
            v = st.prim_sync[2];
        end
        return v;
    endfunction

    // whether the frequency field wants the slow rc or the postscaler output
    always_comb begin
        want_f = 2'h1;
        if (s_ff.internal_freq_select == FREQ_31K &&
            !s_ff.low_freq_source_select) begin
            want_f = 2'h0;
        end
    end

    assign pll_allowed = (primary_osc_config == CFG_INTERNAL_A ||
        primary_osc_config == CFG_INTERNAL_B) &&
        (s_ff.internal_freq_select == FREQ_8M ||
        s_ff.internal_freq_select == FREQ_4M);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        req_src = 2'h0;
        // the 3-stage chain: bit 2 is the level, bits 2 and 1 give edges; only the strap waits for them to agree
        nxt_s.prim_sync = {s_ff.prim_sync[1:0], primary_osc};
        nxt_s.sec_sync = {s_ff.sec_sync[1:0], secondary_osc};
        nxt_s.fast_sync = {s_ff.fast_sync[1:0], fast_internal_osc};
        nxt_s.slow_sync = {s_ff.slow_sync[1:0], slow_internal_rc};
        nxt_s.tss_sync = {s_ff.tss_sync[1:0], two_speed_startup_cfg};
        fast_rise = (s_ff.fast_sync[2:1] == 2'b10);

        // postscaler from the 8 MHz source, 256 for 31.25 kHz
        if (fast_rise) begin
            nxt_s.div_cnt = s_ff.div_cnt + 8'h01;
        end
        case (s_ff.internal_freq_select)
            3'h7: nxt_s.div_clk = s_ff.fast_sync[2];
            3'h6: nxt_s.div_clk = s_ff.div_cnt[0];
            3'h5: nxt_s.div_clk = s_ff.div_cnt[1];
            3'h4: nxt_s.div_clk = s_ff.div_cnt[2];
            3'h3: nxt_s.div_clk = s_ff.div_cnt[3];
            3'h2: nxt_s.div_clk = s_ff.div_cnt[4];
            3'h1: nxt_s.div_clk = s_ff.div_cnt[5];
            default: nxt_s.div_clk = s_ff.div_cnt[7];
        endcase

        if (!s_ff.boot_seen && s_ff.tss_sync[2] == s_ff.tss_sync[1]) begin
            nxt_s.boot_seen = 1'b1;
            nxt_s.primary_ready = ~s_ff.tss_sync[2];
        end

        // startup count of primary cycles in crystal modes
        if (s_ff.prim_sync[2:1] == 2'b10 && !s_ff.ost_cnt[10]) begin
            nxt_s.ost_cnt = s_ff.ost_cnt + 11'h001;
        end
        if (!xtal_mode || s_ff.ost_cnt[10]) begin
            nxt_s.primary_ready = 1'b1;
        end

        // stable after a few fast edges
        if (!fast_osc_enable) begin
            nxt_s.ifs_cnt = 4'h0;
        end else if (fast_rise && s_ff.ifs_cnt != 4'(STABLE_CYCLES)) begin
            nxt_s.ifs_cnt = s_ff.ifs_cnt + 4'h1;
        end

        // ------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------
        if (wr_en) begin
            case (apb_req.paddr[7:0])
                CLK_SEL_CTRL_OFF: begin
                    nxt_s.idle_on_sleep = apb_req.pwdata[IDLE_BIT];
                    nxt_s.internal_freq_select =
                        apb_req.pwdata[FREQ_LSB +: 3];
                    req_src = apb_req.pwdata[1:0];
                    if (!(req_src == SRC_SECONDARY &&
                          !s_ff.secondary_osc_enable)) begin
                        nxt_s.clock_source_select = req_src;
                    end
                end
                TIMER1_CTRL_OFF: nxt_s.secondary_osc_enable =
                    apb_req.pwdata[SEC_EN_BIT];
                OSC_TRIM_OFF: begin
                    nxt_s.low_freq_source_select = apb_req.pwdata[LFS_BIT];
                    nxt_s.freq_multiplier_enable = apb_req.pwdata[PLL_BIT];
                end
                default: ;
            endcase
        end
        if (!(pll_allowed)) begin
            nxt_s.freq_multiplier_enable = 1'b0;
        end

        // ------------------------------------------------------------
        // glitch-free switch
        // ------------------------------------------------------------
        want_src = s_ff.clock_source_select[1] ? 2'h2 :
            s_ff.clock_source_select;
        src_lvl = src_level(s_ff, s_ff.cur_src);
        old_edge = ~src_lvl & s_ff.clk_out;
        // rising edge of the selected source, seen one cycle ahead
        new_edge = ~src_lvl & src_level(nxt_s, s_ff.cur_src);
        case (s_ff.sw)
            SCSW_RUN: begin
                nxt_s.clk_out = src_lvl;
                nxt_s.cur_int_freq = want_f;
                if (want_src != s_ff.cur_src) begin
                    nxt_s.sw = SCSW_DRAIN;
                    nxt_s.edge_cnt = 3'h0;
                end
            end
            SCSW_DRAIN: begin
                nxt_s.clk_out = src_lvl;
                // two old falling edges then park low
                if (old_edge) begin
                    nxt_s.edge_cnt = s_ff.edge_cnt + 3'h1;
                    if (s_ff.edge_cnt == 3'(OLD_EDGES - 1)) begin
                        nxt_s.clk_out = 1'b0;
                        nxt_s.sw = SCSW_FILL;
                        nxt_s.edge_cnt = 3'h0;
                        nxt_s.cur_src = want_src;
                    end
                end
            end
            SCSW_FILL: begin
                // held low while new source settles
                nxt_s.clk_out = 1'b0;
                // count three rising edges of the new source
                if (new_edge && s_ff.edge_cnt != 3'(NEW_EDGES)) begin
                    nxt_s.edge_cnt = s_ff.edge_cnt + 3'h1;
                end
                if (s_ff.edge_cnt == 3'(NEW_EDGES) && !src_lvl) begin
                    nxt_s.sw = SCSW_RUN;
                end
            end
            default: nxt_s.sw = SCSW_RUN;
        endcase

        // ------------------------------------------------------------
        // read data, captured in setup phase
        // ------------------------------------------------------------
        nxt_s.prdata = 32'h0000_0000;
        if (rd_en) begin
            case (apb_req.paddr[7:0])
                CLK_SEL_CTRL_OFF: nxt_s.prdata = {24'h000000, ctrl_rd};
                TIMER1_CTRL_OFF: nxt_s.prdata = {24'h000000, 1'b0,
                    sec_active, 2'b00, s_ff.secondary_osc_enable, 3'h0};
                OSC_TRIM_OFF: nxt_s.prdata = {24'h000000,
                    s_ff.low_freq_source_select,
                    s_ff.freq_multiplier_enable, 6'h00};
                CFG_STATUS_OFF: nxt_s.prdata = {27'h0000000,
                    s_ff.tss_sync[2], primary_osc_config};
                default: ;
            endcase
        end
    end

    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[IDLE_BIT] = s_ff.idle_on_sleep;
        ctrl_rd[FREQ_LSB +: 3] = s_ff.internal_freq_select;
        ctrl_rd[1:0] = s_ff.clock_source_select;
        ctrl_rd[PSD_BIT] = s_ff.primary_ready & s_ff.sw == SCSW_RUN &
            s_ff.cur_src == SRC_PRIMARY;
        ctrl_rd[IFS_BIT] = int_sel & s_ff.sw == SCSW_RUN &
            s_ff.cur_int_freq != 2'h0 &&
            s_ff.ifs_cnt == 4'(STABLE_CYCLES);
    end

    // ----------------------------------------------------------------
    // registers; constant reset values
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
            s_ff.internal_freq_select <= FREQ_RESET;
            s_ff.cur_int_freq <= 2'h1;
            // alternating, so the strap is judged only once it arrived
            s_ff.tss_sync <= 3'h2;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // watchdog always on slow rc
    assign watchdog_clk = s_ff.slow_sync[2];
    // fast oscillator off only when slow rc picked at 000
    assign fast_osc_enable = !(int_sel && s_ff.cur_int_freq == 2'h0);
    // secondary runs whenever enabled, in every mode
    assign secondary_osc_run = s_ff.secondary_osc_enable;
    assign device_clk = s_ff.clk_out;
    assign idle_mode = sleep_request & s_ff.idle_on_sleep;
    assign sleep_mode = sleep_request & ~s_ff.idle_on_sleep;
    assign apb_rsp.prdata = s_ff.prdata;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~hit;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_src_secondary_refused;
        @(posedge pclk) disable iff (!presetn)
        wr_en && apb_req.paddr[7:0] == CLK_SEL_CTRL_OFF &&
        apb_req.pwdata[1:0] == SRC_SECONDARY && !s_ff.secondary_osc_enable
        |=> s_ff.clock_source_select == $past(s_ff.clock_source_select);
    endproperty
    a_src_secondary_refused: assert property (p_src_secondary_refused)
        else $error("secondary selected while disabled");

    property p_flags_exclusive;
        @(posedge pclk) disable iff (!presetn)
        $onehot0({ctrl_rd[PSD_BIT], ctrl_rd[IFS_BIT],
            sec_active});
    endproperty
    a_flags_exclusive: assert property (p_flags_exclusive)
        else $error("more than one status flag set");

    property p_switch_starts;
        @(posedge pclk) disable iff (!presetn)
        s_ff.sw == SCSW_RUN && want_src != s_ff.cur_src |=> s_ff.sw == SCSW_DRAIN;
    endproperty
    a_switch_starts: assert property (p_switch_starts)
        else $error("switch did not start");

    property p_fill_low;
        @(posedge pclk) disable iff (!presetn)
        s_ff.sw == SCSW_FILL |-> !s_ff.clk_out;
    endproperty
    a_fill_low: assert property (p_fill_low)
        else $error("clock not held during switch");

    property p_pll_gate;
        @(posedge pclk) disable iff (!presetn)
        !pll_allowed |=> !s_ff.freq_multiplier_enable;
    endproperty
    a_pll_gate: assert property (p_pll_gate)
        else $error("multiplier enabled when not allowed");

    property p_idle_sleep;
        @(posedge pclk) disable iff (!presetn)
        sleep_request |-> idle_mode == s_ff.idle_on_sleep &&
            sleep_mode == !s_ff.idle_on_sleep;
    endproperty
    a_idle_sleep: assert property (p_idle_sleep)
        else $error("sleep mode decode wrong");

    property p_psd_primary;
        @(posedge pclk) disable iff (!presetn)
        ctrl_rd[PSD_BIT] |-> s_ff.cur_src == SRC_PRIMARY &&
            (s_ff.ost_cnt[10] || !xtal_mode || !s_ff.tss_sync[2]);
    endproperty
    a_psd_primary: assert property (p_psd_primary)
        else $error("startup flag without primary clock");

    property p_drain_to_fill;
        @(posedge pclk) disable iff (!presetn)
        s_ff.sw == SCSW_DRAIN ##1 s_ff.sw == SCSW_FILL |->
            $past(s_ff.edge_cnt) == 3'(OLD_EDGES - 1);
    endproperty
    a_drain_to_fill: assert property (p_drain_to_fill)
        else $error("switch left old source early");

    property p_fill_to_run;
        @(posedge pclk) disable iff (!presetn)
        s_ff.sw == SCSW_FILL ##1 s_ff.sw == SCSW_RUN |->
            $past(s_ff.edge_cnt) == 3'(NEW_EDGES);
    endproperty
    a_fill_to_run: assert property (p_fill_to_run)
        else $error("switch resumed before three new edges");

endmodule // scsw_clock_switch

// *** verif/scsw_osc_model.sv ***
// scsw_osc_model: oscillator sources beside the clock switch, the fast one gated by its enable
// assumes pclk at 100 ns; every source is slower than pclk / 2
`timescale 1ns/1ps
module scsw_osc_model (
    input wire logic fast_osc_enable,
    output logic primary_osc,
    output logic secondary_osc,
    output logic fast_internal_osc,
    output logic slow_internal_rc
);
    // ----------------------------------------------------------------
    // sources
    // ----------------------------------------------------------------
    initial begin
        primary_osc = 1'b0;
        secondary_osc = 1'b0;
        fast_internal_osc = 1'b0;
        slow_internal_rc = 1'b0;
    end
    always #230 primary_osc = ~primary_osc;
    always #610 secondary_osc = ~secondary_osc;
    // fast source stands still while disabled, as the real one stops
    always #170 fast_internal_osc = fast_osc_enable ? ~fast_internal_osc : 1'b0;
    always #890 slow_internal_rc = ~slow_internal_rc;
endmodule // scsw_osc_model

// *** verif/tb_top.sv ***
// tb_top: self-checking bench for the clock source switch
// assumes the oscillator model drives all four source pins
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
    $display("wrong value at %0t: mismatch", $time); end end
module tb_top;
    import scsw_pkg::*;
    typedef struct {logic [31:0] exp; logic [31:0] mask; logic err;} scsw_note_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    scsw_apb_req_t apb_req = '0;
    scsw_apb_rsp_t apb_rsp;
    logic primary_osc, secondary_osc, fast_internal_osc, slow_internal_rc;
    logic [3:0] cfg = 4'h0;
    logic strap = 1'b1;
    logic sleep_request = 1'b0;
    logic device_clk, watchdog_clk, fast_osc_enable, secondary_osc_run;
    logic idle_mode, sleep_mode, ok;
    int err_count = 0;
    int checked = 0;
    integer seed = 32'h6f07;
    int prim_edges, dclk_edges, wd_edges, n8, n4, a;
    logic [31:0] rdata, r;
    scsw_note_t notes[$];
    scsw_note_t note;

    scsw_clock_switch u_dut (.pclk(pclk), .presetn(presetn),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .primary_osc(primary_osc),
        .secondary_osc(secondary_osc), .fast_internal_osc(fast_internal_osc),
        .slow_internal_rc(slow_internal_rc), .primary_osc_config(cfg),
        .two_speed_startup_cfg(strap), .sleep_request(sleep_request),
        .device_clk(device_clk), .watchdog_clk(watchdog_clk),
        .fast_osc_enable(fast_osc_enable),
        .secondary_osc_run(secondary_osc_run), .idle_mode(idle_mode),
        .sleep_mode(sleep_mode));
    scsw_osc_model u_osc (.fast_osc_enable(fast_osc_enable),
        .primary_osc(primary_osc), .secondary_osc(secondary_osc),
        .fast_internal_osc(fast_internal_osc),
        .slow_internal_rc(slow_internal_rc));

    // ----------------------------------------------------------------
    // clock, edge counters, watchdog
    // ----------------------------------------------------------------
    always #50 pclk = ~pclk;
    always @(posedge primary_osc or negedge presetn) begin
        if (!presetn) prim_edges <= 0;
        else prim_edges <= prim_edges + 1;
    end
    initial dclk_edges = 0;
    initial wd_edges = 0;
    always @(posedge device_clk) dclk_edges++;
    always @(posedge watchdog_clk) wd_edges++;
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        summarize();
    end

    // ----------------------------------------------------------------
    // apb master and read monitor
    // ----------------------------------------------------------------
    task automatic apb(input logic [7:0] ad, input logic w,
                       input logic [31:0] d);
        @(posedge pclk);
        apb_req.paddr <= {24'h0, ad};
        apb_req.pwrite <= w;
        apb_req.pwdata <= d;
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
        rdata = apb_rsp.prdata;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] e,
                      input logic [31:0] m, input logic er);
        notes.push_back('{e, m, er});
        apb(ad, 1'b0, 32'h0);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        apb(ad, 1'b1, d);
    endtask
    // bounded polling for a status bit; no data compared
    task automatic poll(input logic [7:0] ad, input int b);
        ok = 1'b0;
        for (int i = 0; i < 3000 && !ok; i++) begin
            rd(ad, 32'h0, 32'h0, 1'b0);
            ok = (rdata[b] === 1'b1);
        end
    endtask
    task automatic count(output int c);
        int s;
        s = dclk_edges;
        repeat (400) @(posedge pclk);
        c = dclk_edges - s;
    endtask
    always @(posedge pclk) begin
        if (apb_req.psel && apb_req.penable && !apb_req.pwrite
                && notes.size() > 0) begin
            note = notes.pop_front();
            `CHK(apb_rsp.prdata & note.mask, note.exp & note.mask)
            `CHK(apb_rsp.pslverr, note.err)
        end
    end

    task automatic summarize();
        if (err_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(CLK_SEL_CTRL_OFF, 32'h40, 32'hff, 1'b0);
        rd(CFG_STATUS_OFF, 32'h10, 32'hff, 1'b0);
        poll(CLK_SEL_CTRL_OFF, PSD_BIT);
        `CHK(ok, 1'b1)
        `CHK(prim_edges >= STARTUP_CYCLES, 1'b1)
        r = $random(seed);
        wr(8'h10, r);
        rd(8'h10, 32'h0, 32'hffffffff, 1'b1);
        wr(OSC_TRIM_OFF, 32'hc0);
        rd(OSC_TRIM_OFF, 32'h80, 32'hc0, 1'b0);
        for (int f = 0; f < 8; f++) begin
            r = $random(seed);
            wr(CLK_SEL_CTRL_OFF, {24'h0, r[0], f[2:0], 4'h0});
            rd(CLK_SEL_CTRL_OFF, {24'h0, r[0], f[2:0], 4'h0}, 32'hf3, 1'b0);
            sleep_request <= 1'b1;
            @(posedge pclk);
            `CHK(idle_mode, r[0])
            `CHK(sleep_mode, ~r[0])
            sleep_request <= 1'b0;
        end
        wr(CLK_SEL_CTRL_OFF, 32'h41);
        rd(CLK_SEL_CTRL_OFF, 32'h0, 32'h03, 1'b0);
        wr(TIMER1_CTRL_OFF, 32'h08);
        @(negedge pclk);
        `CHK(secondary_osc_run, 1'b1)
        wr(CLK_SEL_CTRL_OFF, 32'h41);
        rd(CLK_SEL_CTRL_OFF, 32'h41, 32'h03, 1'b0);
        poll(TIMER1_CTRL_OFF, SEC_ACT_BIT);
        `CHK(ok, 1'b1)
        rd(CLK_SEL_CTRL_OFF, 32'h41, 32'h0f, 1'b0);
        wr(CLK_SEL_CTRL_OFF, 32'h72);
        poll(CLK_SEL_CTRL_OFF, IFS_BIT);
        `CHK(ok, 1'b1)
        rd(CLK_SEL_CTRL_OFF, 32'h76, 32'h7f, 1'b0);
        rd(TIMER1_CTRL_OFF, 32'h08, 32'h48, 1'b0);
        count(n8);
        wr(CLK_SEL_CTRL_OFF, 32'h62);
        count(n4);
        `CHK(n4 < n8 && n4 > 0, 1'b1)
        wr(CLK_SEL_CTRL_OFF, 32'h02);
        repeat (20) @(posedge pclk);
        `CHK(fast_osc_enable, 1'b1)
        wr(OSC_TRIM_OFF, 32'h0);
        repeat (20) @(posedge pclk);
        `CHK(fast_osc_enable, 1'b0)
        a = wd_edges;
        repeat (400) @(posedge pclk);
        `CHK(wd_edges > a, 1'b1)
        cfg <= CFG_INTERNAL_A;
        wr(CLK_SEL_CTRL_OFF, 32'h72);
        wr(OSC_TRIM_OFF, 32'h40);
        rd(OSC_TRIM_OFF, 32'h40, 32'h40, 1'b0);
        wr(CLK_SEL_CTRL_OFF, 32'h52);
        rd(OSC_TRIM_OFF, 32'h00, 32'h40, 1'b0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(CLK_SEL_CTRL_OFF, 32'h40, 32'hf3, 1'b0);
        summarize();
    end
endmodule // tb_top
